/* File: common/temp_alarm_pkg.sv */
// Purpose: Shared constants for the temperature alarm status flag block
// Assumes: 8-bit registers, temperatures as signed 8-bit whole degrees
// Notes:   Register bit positions and reset values live here
package temp_alarm_pkg;
    localparam int NUM_REMOTE        = 6;
    localparam int TEMP_W            = 8;
    localparam int LOCAL_BIT         = 6;
    localparam logic [7:0] STAT1_RESET      = 8'h00;
    localparam logic [7:0] STAT2_RESET      = 8'h00;
    localparam logic [7:0] CFG2_RESET       = 8'h00;
    localparam logic [7:0] CFG3_RESET       = 8'h00;
    localparam logic [7:0] STAT1_VALID_MASK = 8'h7f;
    localparam logic [7:0] STAT2_VALID_MASK = 8'h39;
    localparam logic [7:0] CFG3_VALID_MASK  = 8'h39;
    localparam logic [7:0] HYST_DEG         = 8'h04;
endpackage

/* File: logic/temp_channel_cmp.sv */
// Purpose: One channel's limit compare with release hysteresis
// Assumes: Temperature and limit are signed whole degrees
// Notes:   Condition sets above limit, clears below limit minus hysteresis
`timescale 1ns/1ps
module temp_channel_cmp
    import temp_alarm_pkg::*;
#(
    parameter int W = TEMP_W
) (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              sample,
    input  wire logic signed [W-1:0] temp,
    input  wire logic signed [W-1:0] limit,
    output logic                   cond
);
    logic signed [W:0] rel_lvl;
    logic              above;
    logic              below;

    // One extra bit so limit minus hysteresis cannot wrap
    assign rel_lvl = $signed({limit[W-1], limit})
                     - $signed((W+1)'(HYST_DEG));
    assign above   = temp > limit;
    // Signed cast, else a negative reading compares as a huge value
    assign below   = $signed({temp[W-1], temp}) < rel_lvl;

    // Condition updates only on a finished conversion
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cond <= 1'b0;
        end else if (sample) begin
            if (above) begin
                cond <= 1'b1;
            end else if (below) begin
                cond <= 1'b0;
            end
        end
    end
endmodule

/* File: logic/temp_alarm_status_flags.sv */
// Purpose: Alarm status flags, masks and alarm outputs of a temp monitor
// Assumes: Converter delivers one result with a done pulse per channel
// Notes:   Fault inputs are pins, synchronised before use
// Operation
// - Local above its high limit sets bit 6 of first status.
// - Remote 1 to 6 above high limits set first status bits 0 to 5.
// - Remote 1 above its overtemp limit sets second status bit 0.
// - Remotes 4, 5, 6 over overtemp limits set bits 3, 4, 5.
// - Open or supply-tied diode inputs report a diode fault.
// - Faulted remote channels are skipped in the measurement sequence.
// - A masked channel never drives warning or overtemp alarm outputs.
// - Second status clears only on its read; output stays asserted.
// - Overtemp ends only below threshold minus 4 degrees.
// - Second config bits 0-5 mask remote alerts, bit 6 local.
// - Third config bits 0,3,4,5 mask overtemp of channels 1,4,5,6.
`timescale 1ns/1ps
module temp_alarm_status_flags
    import temp_alarm_pkg::*;
#(
    parameter int NCH = NUM_REMOTE
) (
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    input  wire logic [NCH-1:0]         diode_open_in,
    input  wire logic [NCH-1:0]         diode_anode_high_in,
    input  wire logic                   conv_done,
    input  wire logic [2:0]             conv_chan,
    input  wire logic signed [TEMP_W-1:0] conv_temp,
    input  wire logic [8*TEMP_W-1:0]    alert_limits,
    input  wire logic [8*TEMP_W-1:0]    overtemp_limits,
    input  wire logic                   cfg2_wr,
    input  wire logic                   cfg3_wr,
    input  wire logic [7:0]             cfg_wdata,
    input  wire logic                   stat2_rd,
    output logic [7:0]                  high_alert_flags,
    output logic [7:0]                  overtemp_flags,
    output logic [7:0]                  diode_fault_flags,
    output logic [7:0]                  alert_mask_cfg,
    output logic [7:0]                  overtemp_mask_cfg,
    output logic [2:0]                  next_chan,
    output logic                        alert_out_o,
    output logic                        alert_out_oe,
    output logic                        overtemp_alarm_out_o,
    output logic                        overtemp_alarm_out_oe
);
    import temp_alarm_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers for diode fault detectors
    logic [NCH-1:0] open_s1_q, open_s2_q, high_s1_q, high_s2_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            open_s1_q <= '0;
            open_s2_q <= '0;
            high_s1_q <= '0;
            high_s2_q <= '0;
        end else begin
            open_s1_q <= diode_open_in;
            open_s2_q <= open_s1_q;
            high_s1_q <= diode_anode_high_in;
            high_s2_q <= high_s1_q;
        end
    end

    // Fault reported in bits 1..6, bit 0 and 7 reserved
    logic [NCH-1:0] fault;
    assign fault = open_s2_q | high_s2_q;
    assign diode_fault_flags = {1'b0, fault, 1'b0};

    ////////////////////////////////////////////////////////////////////////
    // Measurement sequence: channel 0 local, 1..6 remote
    function automatic logic [2:0] step(input logic [2:0] cur,
                                        input logic [NCH-1:0] flt);
        logic [2:0] c;
        logic       found;
        c = cur;
        found = 1'b0;
        step = 3'd0;
        for (int i = 0; i < NCH + 1; i++) begin
            c = (c == 3'd6) ? 3'd0 : c + 3'd1;
            if (!found && (c == 3'd0 || !flt[c - 3'd1])) begin
                step = c;
                found = 1'b1;
            end
        end
    endfunction

    logic [2:0] next_chan_d;
    assign next_chan_d = step(next_chan, fault);
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            next_chan <= 3'd0;
        end else if (conv_done) begin
            next_chan <= next_chan_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-channel compares; results from faulted channels are dropped
    logic [NCH:0] samp, alert_c, ot_c;
    genvar g;
    generate
        for (g = 0; g <= NCH; g++) begin : gen_ch
            logic [TEMP_W-1:0] a_lim, o_lim;
            assign a_lim = alert_limits[g*TEMP_W +: TEMP_W];
            assign o_lim = overtemp_limits[g*TEMP_W +: TEMP_W];
            if (g == 0) begin : gen_loc
                assign samp[g] = conv_done && conv_chan == 3'd0;
            end else begin : gen_rem
                assign samp[g] = conv_done && conv_chan == 3'(g)
                                 && !fault[g-1];
            end
            temp_channel_cmp #(.W(TEMP_W)) u_alert (
                .clk(clk), .reset_n(reset_n), .sample(samp[g]),
                .temp(conv_temp), .limit(a_lim), .cond(alert_c[g]));
            temp_channel_cmp #(.W(TEMP_W)) u_ot (
                .clk(clk), .reset_n(reset_n), .sample(samp[g]),
                .temp(conv_temp), .limit(o_lim), .cond(ot_c[g]));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Mask configuration registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            alert_mask_cfg    <= CFG2_RESET;
            overtemp_mask_cfg <= CFG3_RESET;
        end else begin
            if (cfg2_wr) begin
                alert_mask_cfg <= {1'b0, cfg_wdata[6:0]};
            end
            if (cfg3_wr) begin
                overtemp_mask_cfg <= cfg_wdata & CFG3_VALID_MASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status: first tracks conditions, second sticky until read
    logic [7:0] stat1_d, ot_now, stat2_d;
    logic [7:0] ot_prev_q;
    assign stat1_d = {1'b0, alert_c[0], alert_c[6:1]}
                     & STAT1_VALID_MASK;
    assign ot_now  = {2'b00, ot_c[6:4], 2'b00, ot_c[1]}
                     & STAT2_VALID_MASK;
    // New condition wins over a same-cycle read clear
    assign stat2_d = (stat2_rd ? 8'h00 : overtemp_flags)
                     | (ot_now & ~ot_prev_q);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            high_alert_flags <= STAT1_RESET;
            overtemp_flags   <= STAT2_RESET;
            ot_prev_q        <= 8'h00;
        end else begin
            high_alert_flags <= stat1_d;
            overtemp_flags   <= stat2_d;
            ot_prev_q        <= ot_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Open-drain alarms follow live masked conditions, not the read flags
    logic alert_any, ot_any;
    assign alert_any = |(stat1_d[6:0] & ~alert_mask_cfg[6:0]);
    assign ot_any    = |(ot_now & ~overtemp_mask_cfg);
    assign alert_out_o           = 1'b0;
    assign alert_out_oe          = alert_any;
    assign overtemp_alarm_out_o  = 1'b0;
    assign overtemp_alarm_out_oe = ot_any;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_read;
        stat2_rd && !(|(ot_now & ~ot_prev_q));
    endsequence

    a_reserved_zero: assert property (@(posedge clk) disable iff (!reset_n)
        high_alert_flags[7] == 1'b0
        && (overtemp_flags & ~STAT2_VALID_MASK) == 8'h00)
        else $error("reserved status bit set");
    a_stat2_clear: assert property (@(posedge clk) disable iff (!reset_n)
        s_read |=> overtemp_flags == 8'h00)
        else $error("second status not cleared by read");
    a_stat2_hold: assert property (@(posedge clk) disable iff (!reset_n)
        !stat2_rd |=> (~overtemp_flags & $past(overtemp_flags)) == 8'h00)
        else $error("second status bit lost without read");
    a_read_keeps_out: assert property (@(posedge clk) disable iff (!reset_n)
        (stat2_rd && ot_any && !conv_done && !cfg3_wr)
        |=> overtemp_alarm_out_oe)
        else $error("read released overtemp output");
    a_mask_alert: assert property (@(posedge clk) disable iff (!reset_n)
        (alert_mask_cfg[6:0] == 7'h7f) |-> !alert_out_oe)
        else $error("masked alert drove output");
    a_mask_ot: assert property (@(posedge clk) disable iff (!reset_n)
        (overtemp_mask_cfg == CFG3_VALID_MASK) |-> !overtemp_alarm_out_oe)
        else $error("masked overtemp drove output");
    a_local_bit: assert property (@(posedge clk) disable iff (!reset_n)
        (samp[0] && conv_temp > $signed(alert_limits[TEMP_W-1:0]))
        |=> ##1 high_alert_flags[LOCAL_BIT])
        else $error("local alert not flagged");
    a_skip_fault: assert property (@(posedge clk) disable iff (!reset_n)
        (conv_done && next_chan_d != 3'd0)
        |-> !fault[next_chan_d - 3'd1])
        else $error("faulted channel scheduled");
    a_fault_map: assert property (@(posedge clk) disable iff (!reset_n)
        diode_fault_flags[6:1] == (open_s2_q | high_s2_q))
        else $error("diode fault not reported");
endmodule

/* File: verification/conv_feed.sv */
// Purpose: Converter-side model that hands one result to the flag block
// Assumes: A result stands for exactly one cycle after a rising edge
// Notes:   Idle lines show inverted data so stale values never match
`timescale 1ns/1ps
module conv_feed (
    input  wire logic clk,
    output logic      conv_done,
    output logic [2:0] conv_chan,
    output logic [7:0] conv_temp
);
    initial begin
        conv_done = 1'b0;
        conv_chan = 3'h0;
        conv_temp = 8'h00;
    end
    // One-cycle pulse, then scrambled idle lines
    task automatic send(input logic [2:0] ch, input logic [7:0] t);
        @(posedge clk);
        #1;
        conv_done = 1'b1;
        conv_chan = ch;
        conv_temp = t;
        @(posedge clk);
        #1;
        conv_done = 1'b0;
        conv_chan = ~ch;
        conv_temp = ~t;
    endtask
endmodule

/* File: verification/test_temp_alarm_status_flags.sv */
// Purpose: Self-checking bench for the temperature alarm flag block
// Assumes: Alert limit 50 and overtemp limit 70 degrees on all channels
// Notes:   Host strobes are driven 1 ns after the rising edge
`timescale 1ns/1ps
module test_temp_alarm_status_flags;
    import temp_alarm_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [5:0] d_open = 6'h00;
    logic [5:0] d_high = 6'h00;
    logic cfg2_wr = 1'b0;
    logic cfg3_wr = 1'b0;
    logic [7:0] cfg_wdata = 8'h00;
    logic stat2_rd = 1'b0;
    logic done;
    logic [2:0] chan, nxt;
    logic [7:0] temp, ha, ot, df, am, om, ea, eo;
    logic a_oe, o_oe, a_o, o_o;
    int failures = 0;
    int comparisons = 0;
    int i;
    logic [2:0] ot_ch [4] = '{3'h1, 3'h4, 3'h5, 3'h6};

    always #2.5 clk = ~clk;
    conv_feed feed (.clk(clk), .conv_done(done), .conv_chan(chan),
                    .conv_temp(temp));
    temp_alarm_status_flags uut (
        .clk(clk), .reset_n(reset_n), .diode_open_in(d_open),
        .diode_anode_high_in(d_high), .conv_done(done), .conv_chan(chan),
        .conv_temp(temp), .alert_limits({8{8'h32}}),
        .overtemp_limits({8{8'h46}}), .cfg2_wr(cfg2_wr), .cfg3_wr(cfg3_wr),
        .cfg_wdata(cfg_wdata), .stat2_rd(stat2_rd), .high_alert_flags(ha),
        .overtemp_flags(ot), .diode_fault_flags(df), .alert_mask_cfg(am),
        .overtemp_mask_cfg(om), .next_chan(nxt), .alert_out_o(a_o),
        .alert_out_oe(a_oe), .overtemp_alarm_out_o(o_o),
        .overtemp_alarm_out_oe(o_oe));

    ////////////////////////////////////////////////////////////////////////
    // Compare, count and report
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
            failures++;
        end
    endtask
    // Flags land two edges after the result edge
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    // One-cycle host strobe: 0 = second config, 1 = third config
    task automatic wr(input logic sel, input logic [7:0] d);
        @(posedge clk);
        #1;
        cfg2_wr = !sel;
        cfg3_wr = sel;
        cfg_wdata = d;
        @(posedge clk);
        #1;
        cfg2_wr = 1'b0;
        cfg3_wr = 1'b0;
        settle();
    endtask
    task automatic end_of_test;
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog, far beyond the roughly 130 cycles the tests need
    initial begin
        #20000;
        failures++;
        end_of_test();
    end

    initial begin
        repeat (12) @(posedge clk);
        #1 reset_n = 1'b1;
        chk(ha, 8'h00);
        chk(ot, 8'h00);
        chk({6'h0, a_oe, o_oe}, 8'h00);
        // Heat every channel above both limits one at a time
        ea = 8'h00;
        eo = 8'h00;
        for (i = 0; i < 7; i++) begin
            feed.send(i[2:0], 8'h50);
            settle();
            ea |= (i == 0) ? 8'h40 : (8'h01 << (i - 1));
            eo |= (i == 0) ? 8'h00 : ((8'h01 << (i - 1)) & 8'h39);
            chk(ha, ea);
            chk(ot, eo);
        end
        @(posedge clk);
        #1 stat2_rd = 1'b1;
        @(posedge clk);
        #1 stat2_rd = 1'b0;
        settle();
        chk(ot, 8'h00);
        chk({7'h0, o_oe}, 8'h01);
        // 66 sits on the release point and must hold, 65 releases
        for (i = 0; i < 8; i++) begin
            feed.send(ot_ch[i % 4], (i < 4) ? 8'h42 : 8'h41);
            if (i == 3) begin
                settle();
                chk({7'h0, o_oe}, 8'h01);
            end
        end
        settle();
        chk({7'h0, o_oe}, 8'h00);
        // Masking, with the local channel left alone in one step
        wr(1'b0, 8'h3f);
        chk({7'h0, a_oe}, 8'h01);
        wr(1'b0, 8'h7f);
        chk(am, 8'h7f);
        chk({7'h0, a_oe}, 8'h00);
        wr(1'b1, 8'hff);
        chk(om, 8'h39);
        feed.send(3'h1, 8'h50);
        settle();
        chk(ot, 8'h01);
        chk({7'h0, o_oe}, 8'h00);
        wr(1'b1, 8'h00);
        chk({7'h0, o_oe}, 8'h01);
        // Open channel 3, channel 5 anode tied high
        d_open = 6'h04;
        d_high = 6'h10;
        repeat (4) @(posedge clk);
        #1;
        chk(df, 8'h28);
        feed.send(3'h3, 8'h00);
        settle();
        chk({7'h0, ha[2]}, 8'h01);
        for (i = 0; i < 14; i++) begin
            feed.send(nxt, 8'h00);
            chk({7'h0, nxt === 3'h3 || nxt === 3'h5}, 8'h00);
        end
        // Faulted channels 3 and 5 keep their stale alert bits
        settle();
        chk(ha, 8'h14);
        chk(ot, 8'h01);
        chk({6'h0, a_o, o_o}, 8'h00);
        // Mid-run reset clears status and masks at once
        @(posedge clk);
        #1 reset_n = 1'b0;
        @(posedge clk);
        #1;
        chk(ha, 8'h00);
        chk(ot, 8'h00);
        chk(am, 8'h00);
        reset_n = 1'b1;
        settle();
        chk({6'h0, a_oe, o_oe}, 8'h00);
        end_of_test();
    end
endmodule
